/* rtl/pcc_cache.sv */
`timescale 1ns/1ns
module pcc_cache (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cpu_req,
  input wire pcc_pkg::pcc_cpu_req_t cpu_cmd,
  output logic cpu_ready,
  output logic [31:0] cpu_rdata,
  output logic mem_req,
  output pcc_pkg::pcc_mem_req_t mem_cmd,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  function automatic logic [4:0] page_decode(input logic [7:0] a);
    logic in_win;
    logic [7:0] rel;
    in_win = (a >= pcc_pkg::REG_PAGE0) && (a < pcc_pkg::REG_PAGE_END) && (a[1:0] == 2'h0);
    rel = a - pcc_pkg::REG_PAGE0;
    return {in_win, rel[5:2]};
  endfunction

  pcc_pkg::pcc_state_t state;
  pcc_pkg::pcc_cpu_req_t req_q;
  pcc_pkg::pcc_page_t pages [pcc_pkg::PAGES];
  logic [2:0] ctrl, beat, look_word, wr_word;
  logic [pcc_pkg::SETS-1:0] lru;
  logic victim_q;
  logic [31:0] raddr, xaddr, xaddr_q, look_addr, hit_word, wr_data;
  logic in_paged, page_on, kind_on, cacheable, cacheable_q, take;
  logic [3:0] page_idx, wr_strb, fill_seen;
  logic [pcc_pkg::IDX_W-1:0] look_idx;
  logic [pcc_pkg::TAG_W-1:0] way_tag [pcc_pkg::WAYS];
  logic [31:0] way_word [pcc_pkg::WAYS];
  logic [1:0] way_valid, way_dirty, hit, wr_en;
  logic hit_any, hit_way, lru_cur, wr_dirty, tag_wr;
  logic [4:0] reg_page;

  // address path: vector remap first, then page translation
  always_comb begin
    raddr = cpu_cmd.addr;
    if (ctrl[pcc_pkg::CTRL_REMAP_BIT] && cpu_cmd.addr <= pcc_pkg::VECTOR_LAST) begin
      raddr = pcc_pkg::SRAM_BASE | cpu_cmd.addr;
    end
    in_paged = (raddr[31:pcc_pkg::PAGED_LSB] == '0);
    page_idx = raddr[pcc_pkg::PAGED_LSB-1:pcc_pkg::PAGE_LSB];
    page_on = in_paged && pages[page_idx].en;
    kind_on = cpu_cmd.instr ? ctrl[pcc_pkg::CTRL_INSTR_BIT] : ctrl[pcc_pkg::CTRL_DATA_BIT];
    xaddr = raddr;
    if (page_on) begin
      xaddr = {pages[page_idx].vbase, raddr[pcc_pkg::PAGE_LSB-1:0]};
    end
    cacheable = page_on && kind_on;
  end

  assign take = cpu_req && (state == pcc_pkg::ST_IDLE);
  assign look_addr = (state == pcc_pkg::ST_IDLE) ? xaddr : xaddr_q;
  assign look_idx = look_addr[pcc_pkg::TAG_LSB-1:pcc_pkg::IDX_LSB];
  assign look_word = (state == pcc_pkg::ST_WB) ? beat : look_addr[pcc_pkg::IDX_LSB-1:2];

  for (genvar w = 0; w < pcc_pkg::WAYS; w++) begin : g_way
    pcc_way_store u_way (
      .sys_clk(sys_clk),
      .reset(reset),
      .line_idx(look_idx),
      .rd_word(look_word),
      .rd_tag(way_tag[w]),
      .rd_valid(way_valid[w]),
      .rd_dirty(way_dirty[w]),
      .rd_data(way_word[w]),
      .wr_en(wr_en[w]),
      .wr_word(wr_word),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_dirty(wr_dirty),
      .tag_wr(tag_wr),
      .tag_data(look_addr[31:pcc_pkg::TAG_LSB])
    );
    assign hit[w] = way_valid[w] && (way_tag[w] == look_addr[31:pcc_pkg::TAG_LSB]);
  end

  // hits only count in enabled pages for an enabled access kind; other accesses never hit
  assign hit_any = cacheable && (|hit);
  assign hit_way = hit[1];
  assign hit_word = way_word[hit_way];
  assign lru_cur = lru[look_idx];

  always_comb begin
    wr_en = 2'b00;
    wr_word = look_word;
    wr_data = cpu_cmd.wdata;
    wr_strb = cpu_cmd.strb;
    wr_dirty = 1'b0;
    tag_wr = 1'b0;
    if (take && cpu_cmd.we && hit_any) begin
      wr_en[hit_way] = 1'b1;
      wr_dirty = 1'b1;
    end else if (state == pcc_pkg::ST_FILL && mem_ready) begin
      wr_en[victim_q] = 1'b1;
      wr_word = beat;
      wr_data = mem_rdata;
      wr_strb = pcc_pkg::STRB_ALL;
      tag_wr = (beat == pcc_pkg::LAST_BEAT);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= pcc_pkg::ST_IDLE;
      beat <= 3'h0;
      victim_q <= 1'b0;
      cpu_ready <= 1'b0;
    end else begin
      cpu_ready <= 1'b0;
      case (state)
        pcc_pkg::ST_IDLE: begin
          if (take && hit_any) begin
            cpu_ready <= 1'b1;
          end else if (take) begin
            state <= pcc_pkg::ST_ISSUE;
          end
        end
        pcc_pkg::ST_ISSUE: begin
          beat <= 3'h0;
          victim_q <= lru_cur;
          if (!cacheable_q || req_q.we) begin
            state <= pcc_pkg::ST_PASS;
          end else if (way_valid[lru_cur] && way_dirty[lru_cur]) begin
            state <= pcc_pkg::ST_WB;
          end else begin
            state <= pcc_pkg::ST_FILL;
          end
        end
        pcc_pkg::ST_PASS: begin
          if (mem_ready) begin
            cpu_ready <= 1'b1;
            state <= pcc_pkg::ST_IDLE;
          end
        end
        pcc_pkg::ST_WB: begin
          if (mem_ready) begin
            beat <= 3'(beat + 3'h1);
            if (beat == pcc_pkg::LAST_BEAT) begin
              state <= pcc_pkg::ST_FILL;
            end
          end
        end
        pcc_pkg::ST_FILL: begin
          if (mem_ready) begin
            beat <= 3'(beat + 3'h1);
            if (beat == pcc_pkg::LAST_BEAT) begin
              cpu_ready <= 1'b1;
              state <= pcc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state <= pcc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_rdata <= 32'h00000000;
    end else if (take && hit_any && !cpu_cmd.we) begin
      cpu_rdata <= hit_word;
    end else if (state == pcc_pkg::ST_PASS && mem_ready && !req_q.we) begin
      cpu_rdata <= mem_rdata;
    end else if (state == pcc_pkg::ST_FILL && mem_ready && beat == xaddr_q[4:2]) begin
      cpu_rdata <= mem_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      req_q <= '0;
      xaddr_q <= 32'h00000000;
      cacheable_q <= 1'b0;
    end else if (take) begin
      req_q <= cpu_cmd;
      xaddr_q <= xaddr;
      cacheable_q <= cacheable;
    end
  end

  // lru bit names the way to evict next
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lru <= '0;
    end else if (take && hit_any) begin
      lru[look_idx] <= ~hit_way;
    end else if (state == pcc_pkg::ST_FILL && mem_ready && beat == pcc_pkg::LAST_BEAT) begin
      lru[look_idx] <= ~victim_q;
    end
  end

  // memory side holds its request until mem_ready, one word per handshake
  assign mem_req = (state == pcc_pkg::ST_PASS) || (state == pcc_pkg::ST_WB) ||
                   (state == pcc_pkg::ST_FILL);
  always_comb begin
    mem_cmd.we = req_q.we;
    mem_cmd.strb = req_q.strb;
    mem_cmd.addr = xaddr_q;
    mem_cmd.wdata = req_q.wdata;
    if (state == pcc_pkg::ST_WB) begin
      mem_cmd.we = 1'b1;
      mem_cmd.strb = pcc_pkg::STRB_ALL;
      mem_cmd.addr = {way_tag[victim_q], look_idx, beat, 2'b00};
      mem_cmd.wdata = way_word[victim_q];
    end else if (state == pcc_pkg::ST_FILL) begin
      mem_cmd.we = 1'b0;
      mem_cmd.strb = pcc_pkg::STRB_ALL;
      mem_cmd.addr = {xaddr_q[31:pcc_pkg::IDX_LSB], beat, 2'b00};
    end
  end

  // config changes do not flush; software must not remap live cached pages
  assign reg_page = page_decode(reg_addr);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl <= pcc_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == pcc_pkg::REG_CTRL) begin
      ctrl <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < pcc_pkg::PAGES; i++) begin
        pages[i].vbase <= 11'(i);
        pages[i].en <= pcc_pkg::PAGE_EN_RESET;
      end
    end else if (reg_wr && reg_page[4]) begin
      pages[reg_page[3:0]].vbase <= reg_wdata[31:pcc_pkg::PAGE_LSB];
      pages[reg_page[3:0]].en <= reg_wdata[0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        if (reg_addr == pcc_pkg::REG_CTRL) begin
          reg_rdata <= {29'h0000000, ctrl};
        end else if (reg_addr == pcc_pkg::REG_STATUS) begin
          reg_rdata <= {28'h0000000, state != pcc_pkg::ST_IDLE, state};
        end else if (reg_page[4]) begin
          reg_rdata <= {pages[reg_page[3:0]].vbase, 20'h00000, pages[reg_page[3:0]].en};
        end
      end
    end
  end

  // helper: counts fill beats independently of beat
  always_ff @(posedge sys_clk) begin
    if (reset || state == pcc_pkg::ST_ISSUE) begin
      fill_seen <= 4'h0;
    end else if (state == pcc_pkg::ST_FILL && mem_ready) begin
      fill_seen <= 4'(fill_seen + 4'h1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_read_hit;
    take && !cpu_cmd.we && hit_any;
  endsequence
  sequence s_miss_take;
    take && !hit_any;
  endsequence
  sequence s_fill_last;
    state == pcc_pkg::ST_FILL && mem_ready && beat == pcc_pkg::LAST_BEAT;
  endsequence
  sequence s_dirty_victim;
    state == pcc_pkg::ST_ISSUE && cacheable_q && !req_q.we && way_valid[lru_cur] &&
      way_dirty[lru_cur];
  endsequence

  hit_no_wait_a: assert property (s_read_hit |=> cpu_ready && cpu_rdata == $past(hit_word))
    else $error("read hit not answered next cycle");
  fill_end_a: assert property (s_fill_last |-> fill_seen == 4'h7 ##1 cpu_ready)
    else $error("line fill did not take eight beats");
  write_miss_pass_a: assert property (take && cpu_cmd.we && !hit_any |=>
    state == pcc_pkg::ST_ISSUE ##1 (state == pcc_pkg::ST_PASS && mem_req && mem_cmd.we))
    else $error("write miss not forwarded");
  pass_no_alloc_a: assert property (state == pcc_pkg::ST_PASS |-> wr_en == 2'b00)
    else $error("bypass access wrote the store");
  dirty_flush_a: assert property (s_dirty_victim |=> state == pcc_pkg::ST_WB && mem_cmd.we)
    else $error("dirty victim not written back");
  wb_then_fill_a: assert property (state == pcc_pkg::ST_WB && mem_ready &&
    beat == pcc_pkg::LAST_BEAT |=> state == pcc_pkg::ST_FILL && beat == 3'h0 && !mem_cmd.we)
    else $error("fill did not follow write-back");
  mode_gate_a: assert property (take && !(cpu_cmd.instr ? ctrl[pcc_pkg::CTRL_INSTR_BIT] :
    ctrl[pcc_pkg::CTRL_DATA_BIT]) |-> !hit_any ##1 state == pcc_pkg::ST_ISSUE)
    else $error("disabled access kind was cached");
  page_map_a: assert property (take && !ctrl[pcc_pkg::CTRL_REMAP_BIT] &&
    cpu_cmd.addr[31:25] == 7'h00 && pages[cpu_cmd.addr[24:21]].en |->
    xaddr == {pages[cpu_cmd.addr[24:21]].vbase, cpu_cmd.addr[20:0]})
    else $error("page translation wrong");
  bypass_wait_a: assert property (s_miss_take |=> !cpu_ready ##1 !cpu_ready)
    else $error("bypass answered without extra wait");
  remap_a: assert property (take && ctrl[pcc_pkg::CTRL_REMAP_BIT] &&
    cpu_cmd.addr <= pcc_pkg::VECTOR_LAST |-> raddr == (pcc_pkg::SRAM_BASE | cpu_cmd.addr))
    else $error("vector remap wrong");
  victim_lru_a: assert property (state == pcc_pkg::ST_ISSUE |=> victim_q == $past(lru_cur))
    else $error("victim not taken from lru");
  passthrough_a: assert property (take && !page_on ##1 state == pcc_pkg::ST_ISSUE |=>
    mem_req && mem_cmd.addr == $past(raddr, 2))
    else $error("unpaged address altered");
endmodule

/* rtl/pcc_pkg.sv */
package pcc_pkg;
  localparam int WAYS = 2;
  localparam int SETS = 128;
  localparam int LINE_WORDS = 8;
  localparam int IDX_W = 7;
  localparam int WORD_W = 3;
  localparam int TAG_W = 20;
  localparam int PAGES = 16;
  localparam int IDX_LSB = 5;
  localparam int TAG_LSB = 12;
  localparam int PAGE_LSB = 21;
  localparam int PAGED_LSB = 25;
  localparam logic [2:0] LAST_BEAT = 3'h7;
  localparam logic [3:0] STRB_ALL = 4'hF;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PAGE0 = 8'h40;
  localparam logic [7:0] REG_PAGE_END = 8'h80;
  localparam int CTRL_DATA_BIT = 0;
  localparam int CTRL_INSTR_BIT = 1;
  localparam int CTRL_REMAP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic PAGE_EN_RESET = 1'b0;

  localparam logic [31:0] VECTOR_LAST = 32'h0000001F;
  localparam logic [31:0] SRAM_BASE = 32'h00400000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_PASS = 3'b010,
    ST_WB = 3'b011,
    ST_FILL = 3'b100
  } pcc_state_t;

  typedef struct packed {
    logic [10:0] vbase;
    logic en;
  } pcc_page_t;

  typedef struct packed {
    logic we;
    logic instr;
    logic [3:0] strb;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pcc_cpu_req_t;

  typedef struct packed {
    logic we;
    logic [3:0] strb;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pcc_mem_req_t;
endpackage

/* rtl/pcc_way_store.sv */
`timescale 1ns/1ns
module pcc_way_store (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [pcc_pkg::IDX_W-1:0] line_idx,
  input wire logic [pcc_pkg::WORD_W-1:0] rd_word,
  output logic [pcc_pkg::TAG_W-1:0] rd_tag,
  output logic rd_valid,
  output logic rd_dirty,
  output logic [31:0] rd_data,
  input wire logic wr_en,
  input wire logic [pcc_pkg::WORD_W-1:0] wr_word,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  input wire logic wr_dirty,
  input wire logic tag_wr,
  input wire logic [pcc_pkg::TAG_W-1:0] tag_data
);
  logic [31:0] data_mem [pcc_pkg::SETS*pcc_pkg::LINE_WORDS];
  logic [pcc_pkg::TAG_W-1:0] tag_mem [pcc_pkg::SETS];
  logic [pcc_pkg::SETS-1:0] valid;
  logic [pcc_pkg::SETS-1:0] dirty;

  assign rd_data = data_mem[{line_idx, rd_word}];
  assign rd_tag = tag_mem[line_idx];
  assign rd_valid = valid[line_idx];
  assign rd_dirty = dirty[line_idx];

  // data and tags carry no reset; valid gates them
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) begin
          data_mem[{line_idx, wr_word}][8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_en && tag_wr) begin
      tag_mem[line_idx] <= tag_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      valid <= '0;
      dirty <= '0;
    end else if (wr_en && tag_wr) begin
      valid[line_idx] <= 1'b1;
      dirty[line_idx] <= 1'b0;
    end else if (wr_en && wr_dirty) begin
      dirty[line_idx] <= 1'b1;
    end
  end

  dirty_mark_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_en && wr_dirty && !tag_wr |=> dirty[$past(line_idx)] && valid[$past(line_idx)])
    else $error("store hit did not leave the line dirty");

  fill_clean_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    wr_en && tag_wr |=> valid[$past(line_idx)] && !dirty[$past(line_idx)])
    else $error("filled line not valid and clean");
endmodule

/* bench/pcc_mem_model.sv */
`timescale 1ns/1ns
module pcc_mem_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic mem_req,
  input wire pcc_pkg::pcc_mem_req_t mem_cmd,
  output logic mem_ready,
  output logic [31:0] mem_rdata,
  output int rd_beats,
  output int wr_beats
);
  logic [31:0] store [logic [31:0]];
  logic [31:0] last;
  logic [31:0] w;
  logic go;
  function automatic logic [31:0] peek(input logic [31:0] a);
    return store.exists(a) ? store[a] : {a[15:0] ^ a[31:16], ~a[15:0]};
  endfunction
  assign mem_ready = mem_req & go;
  // an idle data bus shows the inverse of the last beat, never a stale copy
  always @(mem_ready or mem_cmd or last or wr_beats) begin
    mem_rdata = mem_ready ? peek({mem_cmd.addr[31:2], 2'h0}) : ~last;
  end
  always @(posedge sys_clk) begin
    go <= slow ? ($urandom % 3 != 0) : 1'b1;
    if (reset) begin
      rd_beats <= 0;
      wr_beats <= 0;
      last <= 32'h0;
    end else if (mem_ready) begin
      last <= mem_rdata;
      if (mem_cmd.we) begin
        w = peek({mem_cmd.addr[31:2], 2'h0});
        for (int b = 0; b < 4; b++) begin
          if (mem_cmd.strb[b]) w[8*b +: 8] = mem_cmd.wdata[8*b +: 8];
        end
        store[{mem_cmd.addr[31:2], 2'h0}] = w;
        wr_beats <= wr_beats + 1;
      end else begin
        rd_beats <= rd_beats + 1;
      end
    end
  end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic sys_clk, reset, cpu_req, cpu_ready, mem_req, mem_ready, reg_wr, reg_rd, slow;
  pcc_pkg::pcc_cpu_req_t cpu_cmd;
  pcc_pkg::pcc_mem_req_t mem_cmd;
  logic [31:0] cpu_rdata, mem_rdata, reg_wdata, reg_rdata, a, d;
  logic [7:0] reg_addr;
  int rd_beats, wr_beats, lat, drd, dwr, failures, n_tests;
  logic [31:0] exp_mem [logic [31:0]];
  logic [10:0] page_vb [16];
  logic page_en [16];
  logic [2:0] ctrl;

  pcc_cache DUT (.sys_clk(sys_clk), .reset(reset), .cpu_req(cpu_req), .cpu_cmd(cpu_cmd),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pcc_mem_model u_mem (.sys_clk(sys_clk), .reset(reset), .slow(slow), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .rd_beats(rd_beats),
    .wr_beats(wr_beats));

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] get(input logic [31:0] p);
    return exp_mem.exists(p) ? exp_mem[p] : {p[15:0] ^ p[31:16], ~p[15:0]};
  endfunction
  // remap first, then the page lookup on the remapped address
  function automatic logic [31:0] phys(input logic [31:0] v);
    logic [31:0] p;
    p = (ctrl[pcc_pkg::CTRL_REMAP_BIT] && v <= pcc_pkg::VECTOR_LAST) ? v | pcc_pkg::SRAM_BASE : v;
    if (p < 32'h02000000 && page_en[p[24:21]]) p = {page_vb[p[24:21]], p[20:0]};
    return {p[31:2], 2'h0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic reg_wr_t(input logic [7:0] ad, input logic [31:0] dv);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dv;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (ad == pcc_pkg::REG_CTRL) ctrl = dv[2:0];
    if (ad >= pcc_pkg::REG_PAGE0 && ad < pcc_pkg::REG_PAGE_END) begin
      page_vb[ad[5:2]] = dv[31:21];
      page_en[ad[5:2]] = dv[0];
    end
  endtask
  task automatic reg_rd_t(input logic [7:0] ad, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
    @(negedge sys_clk);
    chk(reg_rdata, 32'h0);
  endtask
  task automatic cpu(input logic we, input logic ins, input logic [31:0] va,
    input logic [31:0] dv, input logic [3:0] s);
    int r0;
    int w0;
    logic [31:0] p;
    logic [31:0] m;
    r0 = rd_beats;
    w0 = wr_beats;
    p = phys(va);
    @(posedge sys_clk);
    cpu_req <= 1'b1;
    cpu_cmd <= '{we, ins, s, va, dv};
    @(posedge sys_clk);
    cpu_req <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (cpu_ready !== 1'b1 && lat < 300);
    chk({31'h0, cpu_ready}, 32'h1);
    drd = rd_beats - r0;
    dwr = wr_beats - w0;
    m = get(p);
    // byte lanes only merge on stores; a load sees the whole word
    if (we) begin
      for (int b = 0; b < 4; b++) begin
        if (s[b]) m[8*b +: 8] = dv[8*b +: 8];
      end
      exp_mem[p] = m;
    end else begin
      chk(cpu_rdata, m);
    end
  endtask
  task automatic cost(input int l, input int r, input int w);
    chk(32'(lat), 32'(l));
    chk(32'(drd), 32'(r));
    chk(32'(dwr), 32'(w));
  endtask

  initial begin
    #600000;
    failures++;
    summarize();
  end

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    {cpu_req, reg_wr, reg_rd, slow} = 4'h0;
    cpu_cmd = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    failures = 0;
    n_tests = 0;
    ctrl = 3'h0;
    for (int i = 0; i < 16; i++) begin
      page_vb[i] = 11'(i);
      page_en[i] = 1'b0;
    end
    void'($urandom(32'h437400C4));
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    reg_rd_t(pcc_pkg::REG_CTRL, 32'h0);
    reg_rd_t(pcc_pkg::REG_STATUS, 32'h0);
    reg_rd_t(8'h20, 32'h0);
    for (int i = 0; i < 16; i++) reg_rd_t(8'(64 + 4 * i), {11'(i), 21'h0});
    cpu(1'b0, 1'b0, 32'h100, 32'h0, 4'hF);
    cost(3, 1, 0);
    reg_wr_t(pcc_pkg::REG_CTRL, 32'h3);
    reg_wr_t(pcc_pkg::REG_PAGE0, 32'h1);
    cpu(1'b0, 1'b0, 32'h100, 32'h0, 4'hF);
    cost(10, 8, 0);
    cpu(1'b0, 1'b0, 32'h104, 32'h0, 4'hF);
    cost(1, 0, 0);
    cpu(1'b0, 1'b1, 32'h108, 32'h0, 4'hF);
    cost(1, 0, 0);
    cpu(1'b1, 1'b0, 32'h104, $urandom, 4'h5);
    cost(1, 0, 0);
    cpu(1'b0, 1'b0, 32'h104, 32'h0, 4'hF);
    cost(1, 0, 0);
    cpu(1'b0, 1'b0, 32'h1100, 32'h0, 4'hF);
    cost(10, 8, 0);
    cpu(1'b0, 1'b0, 32'h2100, 32'h0, 4'hF);
    cost(18, 8, 8);
    cpu(1'b0, 1'b0, 32'h104, 32'h0, 4'hF);
    cost(10, 8, 0);
    cpu(1'b1, 1'b0, 32'h3F00, $urandom, 4'hF);
    cost(3, 0, 1);
    cpu(1'b0, 1'b0, 32'h3F00, 32'h0, 4'hF);
    cost(10, 8, 0);
    for (int k = 0; k < 2; k++) begin
      cpu(1'b0, 1'b0, 32'h02000100, 32'h0, 4'hF);
      cost(3, 1, 0);
      cpu(1'b0, 1'b0, 32'h00400100, 32'h0, 4'hF);
      cost(3, 1, 0);
    end
    for (int m = 1; m < 4; m++) begin
      reg_wr_t(pcc_pkg::REG_CTRL, 32'(m));
      for (int ins = 0; ins < 2; ins++) begin
        a = 32'h3000 + 32'((m * 2 + ins) * 32);
        cpu(1'b0, 1'(ins), a, 32'h0, 4'hF);
        if (m[ins]) cost(10, 8, 0);
        else cost(3, 1, 0);
        cpu(1'b0, 1'(ins), a, 32'h0, 4'hF);
        if (m[ins]) cost(1, 0, 0);
        else cost(3, 1, 0);
      end
    end
    reg_wr_t(8'h44, 32'h00600FFF);
    reg_rd_t(8'h44, 32'h00600001);
    cpu(1'b0, 1'b0, 32'h00200040, 32'h0, 4'hF);
    cost(10, 8, 0);
    reg_wr_t(pcc_pkg::REG_CTRL, 32'h7);
    cpu(1'b0, 1'b0, 32'h10, 32'h0, 4'hF);
    reg_wr_t(pcc_pkg::REG_CTRL, 32'h3);
    slow <= 1'b1;
    // random traffic over eight tags per set so that hits, misses and evictions mix
    for (int k = 0; k < 300; k++) begin
      a = (($urandom & 32'h1) << 21) | ($urandom & 32'h3F1C);
      d = $urandom;
      cpu(1'($urandom), 1'($urandom), a, d, 4'($urandom % 15 + 1));
    end
    summarize();
  end
endmodule
